/* src/cnt_timer_pkg.sv */
// Shared constants and types for the four-channel counter/timer
package cnt_timer_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_ZC = 3;
  // Mode word bit positions
  localparam int BIT_IE = 7;
  localparam int BIT_CTR = 6;
  localparam int BIT_P256 = 5;
  localparam int BIT_RISE = 4;
  localparam int BIT_TRIG = 3;
  localparam int BIT_TCF = 2;
  localparam int BIT_SRST = 1;
  localparam int BIT_CTL = 0;
  // Vector layout: base in [7:3], channel code in [2:1]
  localparam int VEC_BASE_LSB = 3;
  // Prescaler reload values for divide by 16 and by 256
  localparam logic [7:0] PRESC_16 = 8'h0f;
  localparam logic [7:0] PRESC_256 = 8'hff;
  // Delay count loaded on reload write; an auto-start channel then sits three cycles in ST_ARMED
  localparam logic [1:0] START_DLY = 2'h2;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [4:0] VEC_RST = 5'h00;

  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_WAIT = 2'b01,
    ST_ARMED = 2'b11,
    ST_RUN = 2'b10
  } ch_state_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] reload;
    logic [7:0] count;
    logic [7:0] presc;
    logic [1:0] dly;
    logic tcExp;
    logic pend;
    ch_state_t state;
  } chan_t;

  typedef struct packed {
    logic ceN;
    logic iorqN;
    logic rdN;
    logic m1N;
    logic [1:0] sel;
  } bus_in_t;

  localparam chan_t CHAN_RST = '{MODE_RST, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0, 1'b0, ST_STOP};
endpackage : cnt_timer_pkg

/* src/four_channel_counter_timer.sv */
// Four-channel counter/timer with CPU I/O port and vectored interrupt
// Operation
// - Reset plus reload-follows halts until reload
// - Bit 7 enables zero-count interrupt anytime
// - Bit 6 picks timer or edge counter
// - Bit 5 picks prescale 16 or 256
// - Bit 4 picks rising or falling edge
// - Slope change without software reset acts as an active edge
// - Auto trigger starts after fixed delay
// - Timer reloads at zero without gap
// - External trigger starts timer one clock later
// - Bit 2 means next word is reload
// - No run until reload value loaded
// - Bit 1 software-resets the channel
// - Bit 0 set marks a mode word
// - Reload zero means count 256
// - Timer period is clock times prescale times reload
// - Channel 0 bit0 clear stores vector base
// - Vector bits 2:1 carry channel number
// - Counter mode decrements on active edge
// - Channels 0-2 pulse at zero count
// - New reload applies after current count ends
module four_channel_counter_timer
  import cnt_timer_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // CPU I/O bus
  input wire bus_in_t busIn,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  // Interrupt request, open drain, plus priority chain
  output logic irqOut,
  output logic irqOe,
  input wire logic priorityChainIn,
  output logic priorityChainOut,
  // Channel pins
  input wire logic [NUM_CH-1:0] extEdgeInput,
  output logic [NUM_ZC-1:0] zeroCountPulse
);

  function automatic logic [1:0] lowestPend(input logic [NUM_CH-1:0] p);
    logic [1:0] w;
    w = 2'h0;
    for (int k = NUM_CH - 1; k >= 0; k--)
    begin
      if (p[k])
      begin
        w = 2'(k);
      end
    end
    return w;
  endfunction : lowestPend

  function automatic logic [7:0] prescLoad(input logic [7:0] m);
    return m[BIT_P256] ? PRESC_256 : PRESC_16;
  endfunction : prescLoad

  // Synchronisers: stage 1 feeds stage 2 only
  bus_in_t busS1_reg, busS2_reg;
  logic [7:0] dS1_reg, dS2_reg;
  logic [NUM_CH-1:0] eS1_reg, eS2_reg, ePrev_reg;
  logic chainS1_reg, chainS2_reg;
  logic wrPrev_reg, ackPrev_reg;

  chan_t ch_reg [NUM_CH];
  chan_t ch_next [NUM_CH];
  logic [4:0] base_reg, base_next;
  logic [NUM_ZC-1:0] zc_reg, zc_next;
  logic [7:0] dOut_reg, dOut_next;
  logic dOe_reg, dOe_next;
  logic irqOe_reg, irqOe_next;
  logic chainOut_reg, chainOut_next;

  logic wrLvl, rdLvl, ackLvl, wrStb, ackStb, anyPend;
  logic [NUM_CH-1:0] pendGate, zeroEv, decEv, autoLoad;
  logic [1:0] grant;

  assign wrLvl = !busS2_reg.ceN && !busS2_reg.iorqN && busS2_reg.rdN && busS2_reg.m1N;
  assign rdLvl = !busS2_reg.ceN && !busS2_reg.iorqN && !busS2_reg.rdN && busS2_reg.m1N;
  assign ackLvl = !busS2_reg.iorqN && !busS2_reg.m1N;
  assign wrStb = wrLvl && !wrPrev_reg;
  assign ackStb = ackLvl && !ackPrev_reg;

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      pendGate[i] = ch_reg[i].pend && ch_reg[i].mode[BIT_IE];
    end
  end

  assign anyPend = |pendGate;
  assign grant = lowestPend(pendGate);

  always_comb
  begin
    chan_t c;
    logic act, slopeEdge, dec, hit;
    c = CHAN_RST;
    act = 1'b0;
    slopeEdge = 1'b0;
    dec = 1'b0;
    hit = 1'b0;
    base_next = base_reg;
    zc_next = '0;
    zeroEv = '0;
    decEv = '0;
    autoLoad = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      c = ch_reg[i];
      hit = wrStb && (busS2_reg.sel == 2'(i));
      // A mode write without software reset that flips the slope counts as one active edge
      slopeEdge = hit && !c.tcExp && dS2_reg[BIT_CTL] && !dS2_reg[BIT_SRST]
                  && (dS2_reg[BIT_RISE] != c.mode[BIT_RISE]);
      act = (c.mode[BIT_RISE] ? (eS2_reg[i] && !ePrev_reg[i])
                              : (!eS2_reg[i] && ePrev_reg[i])) || slopeEdge;
      dec = 1'b0;
      if (ackStb && anyPend && grant == 2'(i))
      begin
        c.pend = 1'b0;
      end
      case (c.state)
        ST_ARMED:
        begin
          if (c.mode[BIT_TRIG])
          begin
            if (act)
            begin
              c.state = ST_RUN;
            end
          end
          else if (c.dly != 2'h0)
          begin
            c.dly = c.dly - 2'h1;
          end
          else
          begin
            c.state = ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (c.mode[BIT_CTR])
          begin
            dec = act;
          end
          else if (c.presc == 8'h00)
          begin
            dec = 1'b1;
            c.presc = prescLoad(c.mode);
          end
          else
          begin
            c.presc = c.presc - 8'h01;
          end
        end
        ST_STOP, ST_WAIT:
        begin
          c.presc = c.presc;
        end
        default:
        begin
          c.state = ST_STOP;
        end
      endcase
      if (dec)
      begin
        decEv[i] = 1'b1;
        // Count 0 stands for 256, so zero is reached from 1
        if (c.count == 8'h01)
        begin
          zeroEv[i] = 1'b1;
          c.count = c.reload;
          if (c.mode[BIT_IE])
          begin
            c.pend = 1'b1;
          end
        end
        else
        begin
          c.count = c.count - 8'h01;
        end
      end
      if (hit)
      begin
        if (c.tcExp)
        begin
          c.reload = dS2_reg;
          c.tcExp = 1'b0;
          // A running channel picks this up at its next zero
          if (c.state == ST_STOP || c.state == ST_WAIT)
          begin
            c.count = dS2_reg;
            c.presc = prescLoad(c.mode);
            c.dly = START_DLY;
            c.state = c.mode[BIT_CTR] ? ST_RUN : ST_ARMED;
            autoLoad[i] = !c.mode[BIT_CTR] && !c.mode[BIT_TRIG];
          end
        end
        else if (dS2_reg[BIT_CTL])
        begin
          c.mode = dS2_reg;
          c.tcExp = dS2_reg[BIT_TCF];
          if (dS2_reg[BIT_SRST])
          begin
            c.state = dS2_reg[BIT_TCF] ? ST_WAIT : ST_STOP;
          end
        end
        else if (i == 0)
        begin
          base_next = dS2_reg[7:VEC_BASE_LSB];
        end
      end
      ch_next[i] = c;
    end
    // Channel 3 has no pulse pin, so its zero event only drives the interrupt
    zc_next = zeroEv[NUM_ZC-1:0];
  end

  always_comb
  begin
    dOut_next = dOut_reg;
    dOe_next = 1'b0;
    if (ackStb && anyPend && chainS2_reg)
    begin
      dOut_next = {base_reg, grant, 1'b0};
      dOe_next = 1'b1;
    end
    else if (ackLvl)
    begin
      dOe_next = dOe_reg;
    end
    else if (rdLvl)
    begin
      dOut_next = ch_reg[busS2_reg.sel].count;
      dOe_next = 1'b1;
    end
    irqOe_next = anyPend && chainS2_reg;
    // Lower devices are held off while any channel is pending
    chainOut_next = chainS2_reg && !anyPend;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busS1_reg <= '1;
      busS2_reg <= '1;
      dS1_reg <= 8'h00;
      dS2_reg <= 8'h00;
      eS1_reg <= '0;
      eS2_reg <= '0;
      ePrev_reg <= '0;
      chainS1_reg <= 1'b0;
      chainS2_reg <= 1'b0;
      wrPrev_reg <= 1'b0;
      ackPrev_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        ch_reg[i] <= CHAN_RST;
      end
      base_reg <= VEC_RST;
      zc_reg <= '0;
      dOut_reg <= 8'h00;
      dOe_reg <= 1'b0;
      irqOe_reg <= 1'b0;
      chainOut_reg <= 1'b0;
    end
    else
    begin
      busS1_reg <= busIn;
      busS2_reg <= busS1_reg;
      dS1_reg <= dataIn;
      dS2_reg <= dS1_reg;
      eS1_reg <= extEdgeInput;
      eS2_reg <= eS1_reg;
      ePrev_reg <= eS2_reg;
      chainS1_reg <= priorityChainIn;
      chainS2_reg <= chainS1_reg;
      wrPrev_reg <= wrLvl;
      ackPrev_reg <= ackLvl;
      for (int i = 0; i < NUM_CH; i++)
      begin
        ch_reg[i] <= ch_next[i];
      end
      base_reg <= base_next;
      zc_reg <= zc_next;
      dOut_reg <= dOut_next;
      dOe_reg <= dOe_next;
      irqOe_reg <= irqOe_next;
      chainOut_reg <= chainOut_next;
    end
  end

  assign dataOut = dOut_reg;
  assign dataOe = dOe_reg;
  assign irqOut = 1'b0;
  assign irqOe = irqOe_reg;
  assign priorityChainOut = chainOut_reg;
  assign zeroCountPulse = zc_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic srstTcf0, tcfOnly0, ctrEdge0;
  assign srstTcf0 = wrStb && busS2_reg.sel == 2'h0 && !ch_reg[0].tcExp
                    && dS2_reg[BIT_CTL] && dS2_reg[BIT_SRST] && dS2_reg[BIT_TCF];
  assign tcfOnly0 = wrStb && busS2_reg.sel == 2'h0 && !ch_reg[0].tcExp
                    && dS2_reg[BIT_CTL] && dS2_reg[BIT_TCF];
  assign ctrEdge0 = decEv[0] && ch_reg[0].mode[BIT_CTR] && ch_reg[0].count > 8'h01;

  a_zero_pulse_out: assert property (zeroEv[0] |=> zc_reg[0])
    else $error("zero count pulse missing");
  a_reload_at_zero: assert property (zeroEv[1] |=> ch_reg[1].count == $past(ch_reg[1].reload))
    else $error("counter not reloaded at zero");
  a_srst_halts_chan: assert property (srstTcf0 |=> ch_reg[0].state == ST_WAIT
                                      ##1 (ch_reg[0].state == ST_WAIT) [*2])
    else $error("channel did not halt for reload");
  a_tcf_expects_word: assert property (tcfOnly0 |=> ch_reg[0].tcExp)
    else $error("reload not expected after mode word");
  a_wait_no_count: assert property (ch_reg[0].state == ST_WAIT |-> !decEv[0])
    else $error("channel counted without reload");
  a_auto_start_delay: assert property (autoLoad[0] |=> (ch_reg[0].state == ST_ARMED) [*3]
                                       ##1 ch_reg[0].state == ST_RUN)
    else $error("auto start delay wrong");
  a_counter_edge_dec: assert property (ctrEdge0 |=> ch_reg[0].count == $past(ch_reg[0].count) - 8'h01)
    else $error("edge did not decrement");
  a_presc_reload: assert property (ch_reg[0].state == ST_RUN && !ch_reg[0].mode[BIT_CTR]
                                   && ch_reg[0].presc == 8'h00 && !wrStb
                                   |=> ch_reg[0].presc == $past(prescLoad(ch_reg[0].mode)))
    else $error("prescaler reload wrong");
  a_vector_channel: assert property (ackStb && anyPend && chainS2_reg
                                     |=> dataOe && dataOut[2:1] == $past(grant)
                                         && dataOut[7:3] == base_reg)
    else $error("vector channel code wrong");

  c_timer_zero: cover property (zeroEv[0] && !ch_reg[0].mode[BIT_CTR]);
  c_counter_zero: cover property (zeroEv[1] && ch_reg[1].mode[BIT_CTR]);
  c_irq_ack: cover property (ackStb && anyPend && grant == 2'h2);
endmodule : four_channel_counter_timer

/* verif/cpu_bus_model.sv */
// Host processor I/O bus and daisy-chain model facing the counter/timer
module cpu_bus_model
  import cnt_timer_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Processor bus
  output bus_in_t busIn,
  output logic [7:0] dataIn,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  // Daisy chain
  output logic priorityChainIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] lastData;
  initial
  begin
    busIn = bus_in_t'{1'b1, 1'b1, 1'b1, 1'b1, 2'h0};
    lastData = 8'h00;
    dataIn = 8'hff;
    priorityChainIn = 1'b1;
  end
  // Write is held four clocks, one more than the synchroniser needs
  task automatic io_write(input logic [1:0] ch, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    busIn = bus_in_t'{1'b0, 1'b0, 1'b1, 1'b1, ch};
    dataIn = d;
    lastData = d;
    repeat (4) @(posedge clk_sys);
    #1;
    busIn = bus_in_t'{1'b1, 1'b1, 1'b1, 1'b1, ch};
    // Released bus must not keep showing the old byte
    dataIn = ~lastData;
    repeat (2) @(posedge clk_sys);
  endtask : io_write
  // Read (ack=0) or interrupt acknowledge (ack=1); answer valid 3 clocks after pins
  task automatic io_answer(input logic ack, input logic [1:0] ch, output logic [7:0] d,
    output logic oe);
    @(posedge clk_sys);
    #1;
    busIn = ack ? bus_in_t'{1'b1, 1'b0, 1'b1, 1'b0, ch} : bus_in_t'{1'b0, 1'b0, 1'b0, 1'b1, ch};
    repeat (4) @(posedge clk_sys);
    #1;
    d = dataOut;
    oe = dataOe;
    busIn = bus_in_t'{1'b1, 1'b1, 1'b1, 1'b1, ch};
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : io_answer
endmodule : cpu_bus_model

/* verif/four_channel_counter_timer_tb_top.sv */
// Self-checking bench for the four-channel counter/timer
module four_channel_counter_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cnt_timer_pkg::*;
  typedef struct {
    logic [1:0] ch;
    logic [7:0] mode;
    logic [7:0] rld;
    int edges;
    logic [7:0] cnt;
  } row_t;
  logic clk_sys, rst_n, irqOut, irqOe, priorityChainIn, priorityChainOut, dataOe, oe;
  bus_in_t busIn;
  logic [7:0] dataIn, dataOut, rd;
  logic [3:0] extEdgeInput;
  logic [2:0] zeroCountPulse;
  int failures = 0;
  int nTests = 0;
  int zc[3] = '{0, 0, 0};
  int cyc = 0;
  int t0, t1;
  row_t rows[4] = '{'{2'h0, 8'h57, 8'h03, 1, 8'h02}, '{2'h1, 8'h47, 8'h00, 2, 8'hfe},
    '{2'h2, 8'h57, 8'h05, 4, 8'h01}, '{2'h3, 8'h47, 8'h02, 1, 8'h01}};
  four_channel_counter_timer i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .busIn(busIn),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .irqOut(irqOut), .irqOe(irqOe),
    .priorityChainIn(priorityChainIn), .priorityChainOut(priorityChainOut),
    .extEdgeInput(extEdgeInput), .zeroCountPulse(zeroCountPulse));
  cpu_bus_model i_host (.clk_sys(clk_sys), .busIn(busIn), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .priorityChainIn(priorityChainIn));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++)
      if (zeroCountPulse[i] === 1'b1)
        zc[i] <= zc[i] + 1;
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] act);
    nTests++;
    if (act !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input logic exp, input logic act);
    cmp_byte({7'h00, exp}, {7'h00, act});
  endtask : cmp_bit
  task automatic cmp_count(input int exp, input int act);
    nTests++;
    if (act != exp)
    begin
      failures++;
      $display("MISMATCH at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask : cmp_count
  // Edge held three clocks, then four clocks back, so the two-flop synchroniser cannot miss it
  task automatic pulse_edge(input logic [1:0] ch, input logic rise);
    @(posedge clk_sys);
    #1;
    extEdgeInput[ch] = rise;
    repeat (3) @(posedge clk_sys);
    #1;
    extEdgeInput[ch] = ~rise;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : pulse_edge
  task automatic wait_zc(input int ch, output int at);
    int z;
    z = zc[ch];
    for (int i = 0; i < 1000; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (zc[ch] != z)
      begin
        at = cyc;
        return;
      end
    end
    failures++;
    give_verdict();
  endtask : wait_zc
  initial
  begin
    rst_n = 1'b0;
    extEdgeInput = 4'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp_byte(8'h00, {dataOe, irqOe, priorityChainOut, zeroCountPulse, 2'h0});
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    cmp_bit(1'b1, priorityChainOut);
    foreach (rows[r])
    begin
      extEdgeInput[rows[r].ch] = ~rows[r].mode[BIT_RISE];
      i_host.io_write(rows[r].ch, rows[r].mode);
      i_host.io_write(rows[r].ch, rows[r].rld);
      repeat (rows[r].edges) pulse_edge(rows[r].ch, rows[r].mode[BIT_RISE]);
      i_host.io_answer(1'b0, rows[r].ch, rd, oe);
      cmp_byte(rows[r].cnt, rd);
      cmp_bit(1'b1, oe);
    end
    cmp_count(0, zc[0] + zc[1] + zc[2]);
    pulse_edge(2'h2, 1'b1);
    cmp_count(1, zc[2]);
    repeat (5) pulse_edge(2'h2, 1'b1);
    cmp_count(2, zc[2]);
    i_host.io_write(2'h3, 8'h57);
    i_host.io_write(2'h3, 8'h04);
    i_host.io_write(2'h3, 8'h45);
    i_host.io_answer(1'b0, 2'h3, rd, oe);
    cmp_byte(8'h03, rd);
    for (int p = 0; p < 2; p++)
    begin
      i_host.io_write(2'h0, p ? 8'h27 : 8'h07);
      i_host.io_write(2'h0, p ? 8'h01 : 8'h02);
      wait_zc(0, t0);
      wait_zc(0, t1);
      cmp_count(p ? 256 : 32, t1 - t0);
    end
    i_host.io_write(2'h0, 8'h07);
    t0 = zc[0];
    repeat (600) @(posedge clk_sys);
    cmp_count(t0, zc[0]);
    i_host.io_write(2'h0, 8'h01);
    wait_zc(0, t1);
    // Externally triggered timer must sit idle until its edge arrives
    i_host.io_write(2'h0, 8'h1f);
    i_host.io_write(2'h0, 8'h01);
    t1 = zc[0];
    repeat (100) @(posedge clk_sys);
    #1;
    cmp_count(t1, zc[0]);
    t0 = cyc;
    pulse_edge(2'h0, 1'b1);
    wait_zc(0, t1);
    cmp_count(21, t1 - t0);
    i_host.io_write(2'h0, 8'h03);
    i_host.io_write(2'h0, 8'ha8);
    i_host.io_write(2'h2, 8'hd7);
    i_host.io_write(2'h2, 8'h01);
    pulse_edge(2'h2, 1'b1);
    i_host.io_write(2'h1, 8'ha7);
    i_host.io_write(2'h1, 8'h01);
    wait_zc(1, t0);
    repeat (2) @(posedge clk_sys);
    #1;
    cmp_bit(1'b1, irqOe);
    cmp_bit(1'b0, priorityChainOut);
    cmp_bit(1'b0, irqOut);
    i_host.io_answer(1'b1, 2'h0, rd, oe);
    cmp_byte(8'haa, rd);
    i_host.io_answer(1'b1, 2'h0, rd, oe);
    cmp_byte(8'hac, rd);
    cmp_bit(1'b1, oe);
    // Let channel 1 pend again so that masking it has something to hide
    wait_zc(1, t0);
    cmp_bit(1'b1, irqOe);
    i_host.io_write(2'h1, 8'h03);
    repeat (4) @(posedge clk_sys);
    #1;
    cmp_bit(1'b0, irqOe);
    give_verdict();
  end
endmodule : four_channel_counter_timer_tb_top
